// *** src/lin_break_sync_rx_gate.sv ***
// Hardware sync unit for a single-wire bus: break and sync timers,
// receive gating toward the UART, status flags, interrupt, APB slave.
// Assumes bus_rxd comes from the transceiver and the UART takes uart_rxd.
//
// Notes on behaviour
// - LIN mode, gate set: UART input held high until break and sync seen.
// - LIN mode, gate clear: bus data passes to the UART.
// - Pulse-width read mode, gate set: each rising edge sets status bit 0.
// - Break timer starts on falling edge, stops on next rising edge.
// - Break timer equal to its compare value raises an interrupt.
// - Break timer overflow raises an interrupt for stuck-bus faults.
// - Pulse-width write mode, gate clear: no break interrupts on rising edges.
// - Gate clear during transmit avoids an interrupt on bus release.
// - Write mode: compare status bit 3 marks when to release the bus.
// - In write mode the break timer still stops on rising edges.
// - Stop-edge bit set: sync timer stops on the configured rising edge.
// - Stop-edge bit clear: sync timer stops on the configured falling edge.
// - Mode bit set selects pulse-width bus, clear selects LIN.
// - Sync bit timer equal to compare sets status bit 3 and interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "hsu_consts.svh"
module lin_break_sync_rx_gate
  import hsu_pkg::*;
(
  input  wire logic                   clk,     // System clock, 25 MHz.
  input  wire logic                   rst,     // Asynchronous reset, active high.
  input  wire logic                   psel,    // APB select.
  input  wire logic                   penable, // APB access phase.
  input  wire logic                   pwrite,  // APB write.
  input  wire logic [`HSU_ADDR_W-1:0] paddr,   // APB byte address.
  input  wire logic [31:0]            pwdata,  // APB write data.
  output logic      [31:0]            prdata,  // APB read data.
  output logic                        pready,  // APB ready.
  output logic                        pslverr, // APB error on unmapped address.
  input  wire logic                   bus_rxd, // Bus receive level.
  output logic                        uart_rxd,// Gated receive level to UART.
  output logic                        irq      // Level interrupt.
);
  logic                  lvl, rise, fall;
  logic [`HSU_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [3:0]            ecfg_q, ecfg_d;
  logic [`HSU_TMR_W-1:0] scmp_q, scmp_d, bcmp_q, bcmp_d;
  logic [`HSU_STA_W-1:0] sta_q, sta_d, ien_q, ien_d, clr;
  logic [31:0]           prdata_q, prdata_d;
  logic                  pready_q, pready_d, pslverr_q, pslverr_d;
  logic                  irq_q, irq_d, urx_q, urx_d;
  logic                  en, mode, gate, srise, setup, wr;
  logic [`HSU_TMR_W-1:0] bcnt, scnt;
  logic                  brun, bhit, bovf, srun, shit, sovf;
  logic                  sstart, sstop, sel_edge;
  logic [3:0]            ecnt_q, ecnt_d;
  lin_state_t            st_q, st_d;
  logic                  brk_ok_q, brk_ok_d;

  assign en    = ctrl_q[`HSU_EN_BIT];
  assign mode  = ctrl_q[`HSU_MODE_BIT];
  assign gate  = ctrl_q[`HSU_GATE_BIT];
  assign srise = ctrl_q[`HSU_RISE_BIT];
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & pready_q;

  // Edges come only from the synchronised copy of the bus.
  bus_edge_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .rxd  (bus_rxd),
    .lvl  (lvl),
    .rise (rise),
    .fall (fall)
  );

  // Break timer: falling edge starts, rising edge stops and holds.
  pulse_timer u_brk (
    .clk     (clk),
    .rst     (rst),
    .start   (en & fall),
    .stop    (en & rise),
    .cmp     (bcmp_q),
    .count   (bcnt),
    .running (brun),
    .hit     (bhit),
    .ovf     (bovf)
  );

  // Sync timer: started at the first falling edge, stopped at the Nth selected edge.
  pulse_timer u_syn (
    .clk     (clk),
    .rst     (rst),
    .start   (sstart),
    .stop    (sstop),
    .cmp     (scmp_q),
    .count   (scnt),
    .running (srun),
    .hit     (shit),
    .ovf     (sovf)
  );

  // The starting falling edge counts as falling edge one.
  assign sel_edge = srise ? rise : fall;
  assign sstart   = en & fall & ~srun & (mode | (st_q == LS_WAIT_SYNC));
  assign sstop    = en & srun & sel_edge & (ecnt_q + 4'h1 >= ecfg_q);

  always_comb begin
    ecnt_d = ecnt_q;
    if (sstart) begin
      ecnt_d = srise ? 4'h0 : 4'h1;
    end else if (srun & sel_edge) begin
      ecnt_d = ecnt_q + 4'h1;
    end
  end

  // LIN frame tracking: a low pulse reaching the break compare is a break.
  always_comb begin
    st_d     = st_q;
    brk_ok_d = brk_ok_q;
    if (fall) begin
      brk_ok_d = 1'b0;
    end else if (bhit) begin
      brk_ok_d = 1'b1;
    end
    if (!en || mode) begin
      st_d = LS_WAIT_BREAK;
    end else if (rise && brk_ok_q) begin
      st_d = LS_WAIT_SYNC;
    end else if (st_q == LS_WAIT_SYNC && sstop) begin
      st_d = LS_DATA;
    end
  end

  // UART input: forced high while gated, else follows the bus.
  always_comb begin
    urx_d = lvl;
    if (en && !mode && gate && st_q != LS_DATA) begin
      urx_d = 1'b1;
    end
  end

  // Sticky status: a set in the same cycle as a clear wins.
  always_comb begin
    sta_d = sta_q & ~clr;
    if (mode && gate && rise) begin
      sta_d[`HSU_ST_BRISE] = 1'b1;
    end
    if (bhit) begin
      sta_d[`HSU_ST_BCMP] = 1'b1;
    end
    if (bovf) begin
      sta_d[`HSU_ST_BOVF] = 1'b1;
    end
    if (shit) begin
      sta_d[`HSU_ST_SCMP] = 1'b1;
    end
    if (sstop || sovf) begin
      sta_d[`HSU_ST_SYNC] = 1'b1;
    end
    irq_d = |(sta_q & ien_q);
  end

  // Register writes land only at the access edge with pready high.
  always_comb begin
    ctrl_d = ctrl_q;
    ecfg_d = ecfg_q;
    scmp_d = scmp_q;
    bcmp_d = bcmp_q;
    ien_d  = ien_q;
    clr    = '0;
    if (wr) begin
      unique case (paddr)
        `HSU_CTRL_OFS: ctrl_d = pwdata[`HSU_CTRL_W-1:0];
        `HSU_ECFG_OFS: ecfg_d = pwdata[`HSU_ECFG_MSB:`HSU_ECFG_LSB];
        `HSU_SCMP_OFS: scmp_d = pwdata[`HSU_TMR_W-1:0];
        `HSU_BTMR_OFS: bcmp_d = pwdata[`HSU_TMR_W-1:0];
        `HSU_CLR_OFS:  clr    = pwdata[`HSU_STA_W-1:0];
        `HSU_IEN_OFS:  ien_d  = pwdata[`HSU_STA_W-1:0];
        default:       clr    = '0;
      endcase
    end
  end

  // Read data and error are staged in the setup cycle, so every access
  // completes in its first access cycle.
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    pready_d  = setup;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `HSU_CTRL_OFS: prdata_d[`HSU_CTRL_W-1:0] = ctrl_q;
        `HSU_ECFG_OFS: prdata_d[`HSU_ECFG_MSB:`HSU_ECFG_LSB] = ecfg_q;
        `HSU_SCMP_OFS: prdata_d[`HSU_TMR_W-1:0] = scmp_q;
        `HSU_BTMR_OFS: prdata_d[`HSU_TMR_W-1:0] = bcnt;
        `HSU_STMR_OFS: prdata_d[`HSU_TMR_W-1:0] = scnt;
        `HSU_STAT_OFS: prdata_d[`HSU_STA_W-1:0] = sta_q;
        `HSU_CLR_OFS:  prdata_d = 32'h0000_0000;
        `HSU_IEN_OFS:  prdata_d[`HSU_STA_W-1:0] = ien_q;
        default:       pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= `HSU_CTRL_RST;
      ecfg_q    <= `HSU_ECFG_RST;
      scmp_q    <= `HSU_CMP_RST;
      bcmp_q    <= `HSU_CMP_RST;
      ien_q     <= `HSU_STA_RST;
      sta_q     <= `HSU_STA_RST;
      ecnt_q    <= 4'h0;
      st_q      <= LS_WAIT_BREAK;
      brk_ok_q  <= 1'b0;
      urx_q     <= 1'b1;
      irq_q     <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      ecfg_q    <= ecfg_d;
      scmp_q    <= scmp_d;
      bcmp_q    <= bcmp_d;
      ien_q     <= ien_d;
      sta_q     <= sta_d;
      ecnt_q    <= ecnt_d;
      st_q      <= st_d;
      brk_ok_q  <= brk_ok_d;
      urx_q     <= urx_d;
      irq_q     <= irq_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q; // Only ever set together with pready_q.
  assign uart_rxd = urx_q;
  assign irq      = irq_q;

  // Checks on the block's own outputs and state.
  sequence s_low_pulse_end;
    rise & ~fall;
  endsequence

  sequence s_held_after_stop;
    ~brun ##1 $stable(bcnt);
  endsequence

  AST_GATE_HOLD: assert property (@(posedge clk) disable iff (rst)
    (en && !mode && gate && st_q != LS_DATA) |=> uart_rxd)
    else $error("UART input not held high while gated.");

  AST_PASS: assert property (@(posedge clk) disable iff (rst)
    (en && !mode && !gate) |=> (uart_rxd == $past(lvl)))
    else $error("UART input does not follow the bus.");

  AST_BRK_RISE: assert property (@(posedge clk) disable iff (rst)
    (mode && gate && rise) |=> sta_q[`HSU_ST_BRISE])
    else $error("Rising edge did not set break status.");

  AST_NO_BRK: assert property (@(posedge clk) disable iff (rst)
    (mode && !gate && !sta_q[`HSU_ST_BRISE]) |=> !sta_q[`HSU_ST_BRISE])
    else $error("Break status set with gate clear.");

  AST_BT_STOP: assert property (@(posedge clk) disable iff (rst)
    (en && brun) ##0 s_low_pulse_end |=> s_held_after_stop)
    else $error("Break timer did not stop and hold.");

  AST_BT_CMP: assert property (@(posedge clk) disable iff (rst)
    bhit |=> sta_q[`HSU_ST_BCMP])
    else $error("Break compare did not set status.");

  AST_BT_OVF: assert property (@(posedge clk) disable iff (rst)
    bovf |=> sta_q[`HSU_ST_BOVF] ##1 !brun)
    else $error("Break overflow not reported.");

  AST_SCMP: assert property (@(posedge clk) disable iff (rst)
    (shit && ien_q[`HSU_ST_SCMP]) |=> sta_q[`HSU_ST_SCMP] ##1 irq)
    else $error("Sync compare did not interrupt.");

  AST_SYNC_STOP: assert property (@(posedge clk) disable iff (rst)
    sstop |=> !srun && $stable(scnt))
    else $error("Sync timer ran past its stop edge.");

  AST_APB_ONE: assert property (@(posedge clk) disable iff (rst)
    (psel && !penable) |=> pready)
    else $error("APB access not answered in one cycle.");
endmodule
`default_nettype wire

// *** src/hsu_consts.svh ***
// Constants of the hardware sync unit: register offsets, field positions,
// reset values and widths. Assumes inclusion by bare name from src/.
`ifndef HSU_CONSTS_SVH
`define HSU_CONSTS_SVH
`define HSU_ADDR_W      8
`define HSU_TMR_W       16
`define HSU_STA_W       5
`define HSU_CTRL_OFS    8'h00
`define HSU_ECFG_OFS    8'h04
`define HSU_SCMP_OFS    8'h08
`define HSU_BTMR_OFS    8'h0c
`define HSU_STMR_OFS    8'h10
`define HSU_STAT_OFS    8'h14
`define HSU_CLR_OFS     8'h18
`define HSU_IEN_OFS     8'h1c
`define HSU_EN_BIT      0
`define HSU_MODE_BIT    1
`define HSU_RISE_BIT    7
`define HSU_GATE_BIT    8
`define HSU_CTRL_W      9
`define HSU_ECFG_LSB    4
`define HSU_ECFG_MSB    7
`define HSU_ST_BRISE    0
`define HSU_ST_BCMP     1
`define HSU_ST_BOVF     2
`define HSU_ST_SCMP     3
`define HSU_ST_SYNC     4
`define HSU_CTRL_RST    9'h000
`define HSU_ECFG_RST    4'h5
`define HSU_TMR_RST     16'h0000
`define HSU_CMP_RST     16'hffff
`define HSU_STA_RST     5'h00
`endif

// *** src/hsu_pkg.sv ***
// Types shared by the hardware sync unit files.
// Assumes nothing beyond a SystemVerilog compiler.
package hsu_pkg;
  typedef enum logic [1:0] {
    LS_WAIT_BREAK,
    LS_WAIT_SYNC,
    LS_DATA
  } lin_state_t;
endpackage

// *** src/bus_edge_sync.sv ***
// Bus input synchroniser with rise and fall detection.
// Assumes the bus idles high and rxd may change at any time.
`timescale 1ns/100ps
`default_nettype none
module bus_edge_sync (
  input  wire logic clk,   // System clock.
  input  wire logic rst,   // Asynchronous reset, active high.
  input  wire logic rxd,   // Raw bus level.
  output logic      lvl,   // Synchronised bus level.
  output logic      rise,  // One-cycle pulse on a rising edge.
  output logic      fall   // One-cycle pulse on a falling edge.
);
  logic s1_q, s2_q, s3_q, rise_q, fall_q;
  logic s1_d, s2_d, s3_d, rise_d, fall_d;

  // Only s2 reads s1, so a metastable s1 never reaches the edge logic.
  always_comb begin
    s1_d   = rxd;
    s2_d   = s1_q;
    s3_d   = s2_q;
    rise_d = s2_q & ~s3_q;
    fall_d = ~s2_q & s3_q;
  end

  // Idle-high reset keeps a quiet bus from showing a false edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign lvl  = s3_q;
  assign rise = rise_q;
  assign fall = fall_q;
endmodule
`default_nettype wire

// *** src/pulse_timer.sv ***
// Start/stop cycle timer with compare and overflow pulses.
// Assumes start and stop are one-cycle pulses; start wins if both come.
`timescale 1ns/100ps
`default_nettype none
`include "hsu_consts.svh"
module pulse_timer (
  input  wire logic                  clk,     // System clock.
  input  wire logic                  rst,     // Asynchronous reset, active high.
  input  wire logic                  start,   // Clear and run.
  input  wire logic                  stop,    // Halt, holding the count.
  input  wire logic [`HSU_TMR_W-1:0] cmp,     // Compare value.
  output logic      [`HSU_TMR_W-1:0] count,   // Current or held count.
  output logic                       running, // Timer is counting.
  output logic                       hit,     // Pulse: count equals compare.
  output logic                       ovf      // Pulse: count reached max; the timer halts there.
);
  logic [`HSU_TMR_W-1:0] cnt_q, cnt_d;
  logic                  run_q, run_d, hit_q, hit_d, ovf_q, ovf_d;

  // Overflow halts the timer so a stuck bus is reported once, not repeatedly.
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    hit_d = 1'b0;
    ovf_d = 1'b0;
    if (start) begin
      cnt_d = `HSU_TMR_RST;
      run_d = 1'b1;
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q) begin
      hit_d = (cnt_q == cmp);
      if (&cnt_q) begin
        ovf_d = 1'b1;
        run_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `HSU_TMR_RST;
      run_q <= 1'b0;
      hit_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      hit_q <= hit_d;
      ovf_q <= ovf_d;
    end
  end

  assign count   = cnt_q;
  assign running = run_q;
  assign hit     = hit_q;
  assign ovf     = ovf_q;
endmodule
`default_nettype wire

// *** testbench/bus_node_model.sv ***
// Model of a remote node on the single-wire bus, driving the receive line.
// Assumes the bench calls its tasks; the bus rests high through its pull-up.
`timescale 1ns/100ps
`default_nettype none
module bus_node_model (
  input  wire logic clk,  // System clock.
  output var logic  line  // Bus level seen by the unit.
);
  // The recessive level is high, so the line starts and rests there.
  initial line = 1'b1;

  // Low pulse of n clocks, changed just after a rising edge.
  task automatic pulse(input int n);
    @(posedge clk);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
  endtask

  // One character of t clocks a bit: start, eight data bits LSB first, stop.
  task automatic frame(input logic [7:0] b, input int t);
    logic [9:0] bits;
    bits = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line <= bits[i];
      repeat (t - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/test_lin_break_sync_rx_gate.sv ***
// Self-checking bench for the bus sync unit: registers, pulse timing,
// interrupt and receive gating. Assumes src/ is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "hsu_consts.svh"
module test_lin_break_sync_rx_gate;
  logic        clk         = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic        er;
  logic        pready;
  logic        pslverr;
  logic        bus_rxd;
  logic        uart_rxd;
  logic        irq;
  logic        watch       = 1'b0;
  logic        leak        = 1'b0;
  int          n_fail      = 0;
  int          check_count = 0;

  always #20 clk = ~clk;

  lin_break_sync_rx_gate lin_break_sync_rx_gate_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_rxd(bus_rxd), .uart_rxd(uart_rxd), .irq(irq));
  bus_node_model bus_node_model_i (.clk(clk), .line(bus_rxd));

  // While gating is expected the UART must never see a low level.
  // Reset clears the flag, so each gated scenario starts from a clean slate.
  always @(posedge clk) begin
    if (rst) leak <= 1'b0;
    else if (watch && uart_rxd !== 1'b1) leak <= 1'b1;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Range compare; an unknown value never counts as inside the range.
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; the idle edge first keeps strobes from double assignment.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Reset values, read-only and write-only places, the unmapped address.
  task automatic t_regs();
    logic [7:0]  ofs [6] = '{`HSU_CTRL_OFS, `HSU_ECFG_OFS, `HSU_SCMP_OFS,
                            `HSU_STAT_OFS, `HSU_CLR_OFS, `HSU_IEN_OFS};
    logic [31:0] exp [6] = '{`HSU_CTRL_RST, {`HSU_ECFG_RST, 4'h0}, `HSU_CMP_RST,
                            `HSU_STA_RST, 32'h0, 32'h0};
    do_reset();
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      chk(rv, exp[i], exp[i]);
    end
    wr(`HSU_STAT_OFS, 32'h1f);
    rd(`HSU_STAT_OFS);
    chk(rv, 32'h0, 32'h0);
    wr(`HSU_CTRL_OFS, 32'h183);
    rd(`HSU_CTRL_OFS);
    chk(rv, 32'h183, 32'h183);
    rd(8'h20);
    chk({31'h0, er}, 32'h1, 32'h1);
    chk(rv, 32'h0, 32'h0);
  endtask

  // Read mode with gate set: edge flag, compare flag, held width, masking.
  task automatic t_read();
    logic [31:0] m;
    do_reset();
    wr(`HSU_BTMR_OFS, 32'ha);
    wr(`HSU_IEN_OFS, 32'h1);
    wr(`HSU_CTRL_OFS, 32'h103);
    bus_node_model_i.pulse(20);
    repeat (8) @(posedge clk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rd(`HSU_STAT_OFS);
    chk(rv & 32'h3, 32'h3, 32'h3);
    rd(`HSU_BTMR_OFS);
    chk(rv, 32'd19, 32'd21);
    m = rv;
    repeat (10) @(posedge clk);
    rd(`HSU_BTMR_OFS);
    chk(rv, m, m);
    wr(`HSU_CLR_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0, 32'h0);
    rd(`HSU_STAT_OFS);
    chk(rv & 32'h3, 32'h2, 32'h2);
  endtask

  // Write mode with gate clear: no edge flag, sync compare marks release.
  task automatic t_write();
    do_reset();
    wr(`HSU_SCMP_OFS, 32'h8);
    wr(`HSU_IEN_OFS, 32'h9);
    wr(`HSU_CTRL_OFS, 32'h003);
    bus_node_model_i.pulse(20);
    repeat (8) @(posedge clk);
    rd(`HSU_STAT_OFS);
    chk(rv & 32'h9, 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rd(`HSU_BTMR_OFS);
    chk(rv, 32'd19, 32'd21);
  endtask

  // LIN gated: break, then a 0x55 sync byte; stop edge picks the sync width.
  task automatic t_lin(input logic rise, input logic [31:0] lo, input logic [31:0] hi);
    do_reset();
    wr(`HSU_BTMR_OFS, 32'ha);
    wr(`HSU_CTRL_OFS, rise ? 32'h181 : 32'h101);
    watch <= 1'b1;
    bus_node_model_i.pulse(20);
    repeat (10) @(posedge clk);
    fork
      bus_node_model_i.frame(8'h55, 10);
      begin
        repeat (70) @(posedge clk);
        watch <= 1'b0;
      end
    join
    repeat (4) @(posedge clk);
    chk({31'h0, leak}, 32'h0, 32'h0);
    rd(`HSU_STMR_OFS);
    chk(rv, lo, hi);
    rd(`HSU_STAT_OFS);
    chk(rv & 32'h10, 32'h10, 32'h10);
    fork
      bus_node_model_i.pulse(8);
      begin
        repeat (7) @(posedge clk);
        chk({31'h0, uart_rxd}, 32'h0, 32'h0);
      end
    join
  endtask

  // LIN with gate clear: receive data reaches the UART.
  task automatic t_open();
    do_reset();
    wr(`HSU_CTRL_OFS, 32'h001);
    fork
      bus_node_model_i.pulse(8);
      begin
        repeat (7) @(posedge clk);
        chk({31'h0, uart_rxd}, 32'h0, 32'h0);
      end
    join
  endtask

  // A stuck-low bus must end in the overflow flag and an interrupt.
  task automatic t_ovf();
    do_reset();
    wr(`HSU_IEN_OFS, 32'h4);
    wr(`HSU_CTRL_OFS, 32'h003);
    bus_node_model_i.pulse(65560);
    repeat (8) @(posedge clk);
    rd(`HSU_STAT_OFS);
    chk(rv & 32'h4, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1, 32'h1);
  endtask

  // Main sequence; every scenario resets first so none depends on another.
  initial begin
    rst     <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    t_regs();
    t_read();
    t_write();
    t_lin(1'b0, 32'd78, 32'd82);
    t_lin(1'b1, 32'd88, 32'd92);
    t_open();
    t_ovf();
    summarize();
  end
endmodule
`default_nettype wire
